/* dps_pkg.sv */
// Behaviour
// - semaphore access uses select low with address, chip select, read/write as sram
// - flags active low: write zero requests, write one releases
// - controller drops select or output enable between polling reads
// - claim by write zero then read back; zero read means owned
// - after failed request keep reading or write one
// - controller writes one to all eight tokens after power-up; the code does so only when given CMD_INIT, not at reset
package dps_pkg;
  // ****************************************
  // geometry and timing
  // ****************************************
  localparam int unsigned NUM_FLAGS = 8;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SETUP_NS = 20;
  localparam int unsigned STROBE_NS = 20;
  localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] CNT_SETUP = 8'(SETUP_CYC);
  localparam logic [7:0] CNT_STROBE = 8'(STROBE_CYC);
  // user commands
  localparam logic [1:0] CMD_CLAIM = 2'h0;
  localparam logic [1:0] CMD_RELEASE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_INIT = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WSETUP, ST_WSTROBE, ST_GAP, ST_RSETUP, ST_RSAMPLE, ST_DONE
  } dps_state_t;
endpackage

/* dps_sem_host.sv */
`timescale 1ns/10ps
`default_nettype none
module dps_sem_host #(
  parameter int unsigned DATA_W = 18,
  parameter int unsigned ADDR_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [2:0] cmd_index,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_owned,
  output logic rsp_flag,
  output logic token_space_select_n,
  output logic array_select_n,
  output logic write_n,
  output logic out_enable_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in
);
  // refuse widths the address padding or data replication cannot serve
  if (ADDR_W <= dps_pkg::IDX_W || DATA_W < 1) begin : g_bad_widths
    $error("dps_sem_host: bad widths");
  end

  // ****************************************
  // reset release and pin synchroniser
  // ****************************************
  logic [1:0] rst_sync_r;
  logic rst_ok;
  logic din0_s1_r, din0_s2_r, din0_s3_r, din0_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_ok = rst_sync_r[1];

  // only bit zero matters: a read replicates the flag on every line
  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      din0_s1_r <= 1'b1;
      din0_s2_r <= 1'b1;
      din0_s3_r <= 1'b1;
      din0_r <= 1'b1;
    end else begin
      din0_s1_r <= data_in[0];
      din0_s2_r <= din0_s1_r;
      din0_s3_r <= din0_s2_r;
      if (din0_s2_r == din0_s3_r) begin
        din0_r <= din0_s3_r;
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  dps_pkg::dps_state_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [1:0] op_r, op_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic wbit_r, wbit_nxt;
  logic sel_n_r, sel_n_nxt, wr_n_r, wr_n_nxt, oe_n_r, oe_n_nxt, doe_r, doe_nxt;
  logic rdy_r, rdy_nxt, rv_r, rv_nxt, own_r, own_nxt, flag_r, flag_nxt;
  logic [1:0] settle_r, settle_nxt;

  // next-state: init loops all tokens, claim writes then reads back
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    op_nxt = op_r;
    idx_nxt = idx_r;
    wbit_nxt = wbit_r;
    sel_n_nxt = sel_n_r;
    wr_n_nxt = wr_n_r;
    oe_n_nxt = oe_n_r;
    doe_nxt = doe_r;
    rdy_nxt = rdy_r;
    rv_nxt = 1'b0;
    own_nxt = own_r;
    flag_nxt = flag_r;
    settle_nxt = settle_r;
    unique case (st_r)
      dps_pkg::ST_IDLE: begin
        if (cmd_valid && rdy_r) begin
          op_nxt = cmd_op;
          idx_nxt = (cmd_op == dps_pkg::CMD_INIT) ? 3'h0 : cmd_index;
          wbit_nxt = (cmd_op != dps_pkg::CMD_CLAIM);
          rdy_nxt = 1'b0;
          sel_n_nxt = 1'b0;
          cnt_nxt = dps_pkg::CNT_SETUP;
          if (cmd_op == dps_pkg::CMD_READ) begin
            oe_n_nxt = 1'b0;
            st_nxt = dps_pkg::ST_RSETUP;
          end else begin
            doe_nxt = 1'b1;
            st_nxt = dps_pkg::ST_WSETUP;
          end
        end
      end
      dps_pkg::ST_WSETUP: begin
        if (cnt_r == 8'h0) begin
          wr_n_nxt = 1'b0;
          cnt_nxt = dps_pkg::CNT_STROBE;
          st_nxt = dps_pkg::ST_WSTROBE;
        end else begin
          cnt_nxt = cnt_r - 8'h1;
        end
      end
      dps_pkg::ST_WSTROBE: begin
        if (cnt_r == 8'h0) begin
          // rising write strobe latches the request
          wr_n_nxt = 1'b1;
          sel_n_nxt = 1'b1;
          cnt_nxt = dps_pkg::CNT_SETUP;
          st_nxt = dps_pkg::ST_GAP;
        end else begin
          cnt_nxt = cnt_r - 8'h1;
        end
      end
      dps_pkg::ST_GAP: begin
        doe_nxt = 1'b0;
        if (cnt_r == 8'h0) begin
          if (op_r == dps_pkg::CMD_CLAIM) begin
            // write then read back, never the other way round
            sel_n_nxt = 1'b0;
            oe_n_nxt = 1'b0;
            cnt_nxt = dps_pkg::CNT_SETUP;
            st_nxt = dps_pkg::ST_RSETUP;
          end else if (op_r == dps_pkg::CMD_INIT && idx_r != 3'h7) begin
            idx_nxt = idx_r + 3'h1;
            sel_n_nxt = 1'b0;
            doe_nxt = 1'b1;
            cnt_nxt = dps_pkg::CNT_SETUP;
            st_nxt = dps_pkg::ST_WSETUP;
          end else begin
            st_nxt = dps_pkg::ST_DONE;
          end
        end else begin
          cnt_nxt = cnt_r - 8'h1;
        end
      end
      dps_pkg::ST_RSETUP: begin
        // wait out access time plus the three-stage pin sampler
        if (cnt_r == 8'h0) begin
          settle_nxt = 2'h3;
          st_nxt = dps_pkg::ST_RSAMPLE;
        end else begin
          cnt_nxt = cnt_r - 8'h1;
        end
      end
      dps_pkg::ST_RSAMPLE: begin
        if (settle_r == 2'h0) begin
          flag_nxt = din0_r;
          own_nxt = !din0_r;
          // drop both strobes so the next poll sees a fresh value
          sel_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          st_nxt = dps_pkg::ST_DONE;
        end else begin
          settle_nxt = settle_r - 2'h1;
        end
      end
      dps_pkg::ST_DONE: begin
        rv_nxt = 1'b1;
        if (op_r == dps_pkg::CMD_RELEASE || op_r == dps_pkg::CMD_INIT) begin
          own_nxt = 1'b0;
          flag_nxt = 1'b1;
        end
        rdy_nxt = 1'b1;
        st_nxt = dps_pkg::ST_IDLE;
      end
    endcase
  end

  // register everything; select, write and output-enable pins idle high (standby)
  always_ff @(posedge core_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      st_r <= dps_pkg::ST_IDLE;
      cnt_r <= 8'h0;
      op_r <= 2'h0;
      idx_r <= 3'h0;
      wbit_r <= 1'b1;
      sel_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      doe_r <= 1'b0;
      rdy_r <= 1'b1;
      rv_r <= 1'b0;
      own_r <= 1'b0;
      flag_r <= 1'b1;
      settle_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      op_r <= op_nxt;
      idx_r <= idx_nxt;
      wbit_r <= wbit_nxt;
      sel_n_r <= sel_n_nxt;
      wr_n_r <= wr_n_nxt;
      oe_n_r <= oe_n_nxt;
      doe_r <= doe_nxt;
      rdy_r <= rdy_nxt;
      rv_r <= rv_nxt;
      own_r <= own_nxt;
      flag_r <= flag_nxt;
      settle_r <= settle_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign token_space_select_n = sel_n_r;
  assign array_select_n = 1'b1;
  assign write_n = wr_n_r;
  assign out_enable_n = oe_n_r;
  assign addr = {{(ADDR_W-dps_pkg::IDX_W){1'b0}}, idx_r};
  assign data_out = {DATA_W{wbit_r}};
  assign data_oe = doe_r;
  assign cmd_ready = rdy_r;
  assign rsp_valid = rv_r;
  assign rsp_owned = own_r;
  assign rsp_flag = flag_r;
endmodule
`default_nettype wire

/* dps_sem_host_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// port checks
// ****
module dps_sem_host_monitor #(
  parameter int unsigned DATA_W = 18,
  parameter int unsigned ADDR_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [2:0] cmd_index,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_owned,
  input wire logic rsp_flag,
  input wire logic token_space_select_n,
  input wire logic array_select_n,
  input wire logic write_n,
  input wire logic out_enable_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic [DATA_W-1:0] data_in
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_ARRAY_OFF: assert property (array_select_n)
    else $error("array select active");
  AST_ADDR_HI: assert property (!token_space_select_n |-> addr[ADDR_W-1:3] == '0)
    else $error("high address bits set");
  AST_DATA_ALL: assert property (data_oe |-> (data_out == '0 || &data_out)
      && (!token_space_select_n || !$past(token_space_select_n)))
    else $error("data driven outside a token access");
  AST_WR_SEL: assert property (!write_n |-> !token_space_select_n && data_oe)
    else $error("write strobe without select");
  AST_NO_FIGHT: assert property (!out_enable_n |-> !data_oe && write_n)
    else $error("read while driving");
  AST_WR_HOLD: assert property (!write_n && !$past(write_n)
      |-> $stable(addr) && $stable(data_out))
    else $error("write moved under strobe");
  AST_RSP_BOUND: assert property (cmd_valid && cmd_ready
      |=> !cmd_ready ##[0:200] rsp_valid)
    else $error("no response");
  AST_OWN_FLAG: assert property (rsp_valid && rsp_owned
      |-> !rsp_flag ##1 !rsp_valid)
    else $error("owned with flag high");
  C_CLAIM_WON: cover property (rsp_valid && rsp_owned);
  C_CLAIM_LOST: cover property (rsp_valid && !rsp_owned && rsp_flag);
  C_READ: cover property ($fell(out_enable_n));
endmodule
bind dps_sem_host dps_sem_host_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mon (.*);
`default_nettype wire

/* dps_sem_host_tb.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// bench
// ****
module dps_sem_host_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [2:0] cmd_index = 3'h0;
  logic cmd_ready, rsp_valid, rsp_owned, rsp_flag, data_oe;
  logic token_space_select_n, array_select_n, write_n, out_enable_n;
  logic [15:0] addr;
  logic [17:0] data_out, data_in, q_b;
  logic sel_n_b = 1'b1;
  logic we_n_b = 1'b1;
  logic oe_n_b = 1'b1;
  logic d_b = 1'b1;
  logic [2:0] ix_b = 3'h0;
  int n_errors = 0;
  int samples_checked = 0;
  dps_sem_host DUT (.*);
  dps_sem_model u_dev (.sel_n_a(token_space_select_n), .we_n_a(write_n), .oe_n_a(out_enable_n),
    .ix_a(addr[2:0]), .d_a(data_out[0]), .q_a(data_in), .sel_n_b(sel_n_b), .we_n_b(we_n_b),
    .oe_n_b(oe_n_b), .ix_b(ix_b), .d_b(d_b), .q_b(q_b));
  initial forever #5 core_clk = ~core_clk;
  task automatic report_and_stop;
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one command, then compare {owned, flag} under a mask
  task automatic cmd(input logic [1:0] op, input logic [2:0] ix, input logic [1:0] e,
    input logic [1:0] m);
    int n;
    n = 0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_index = ix;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 300) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, rsp_valid, 1'b1);
    end
    chk(18'({rsp_owned, rsp_flag} & m), 18'(e));
  endtask
  // far port write and read, driven as the other processor would
  task automatic bw(input logic [2:0] ix, input logic d);
    @(negedge core_clk);
    ix_b = ix;
    d_b = d;
    sel_n_b = 1'b0;
    we_n_b = 1'b0;
    @(negedge core_clk);
    we_n_b = 1'b1;
    sel_n_b = 1'b1;
  endtask
  task automatic br(input logic [2:0] ix, input logic [17:0] e);
    @(negedge core_clk);
    ix_b = ix;
    sel_n_b = 1'b0;
    oe_n_b = 1'b0;
    @(negedge core_clk);
    chk(q_b, e);
    sel_n_b = 1'b1;
    oe_n_b = 1'b1;
  endtask
  task automatic t_init;
    cmd(2'h3, 3'h0, 2'h1, 2'h1);
    for (int i = 0; i < 8; i++) bw(3'(i), 1'b1);
    br(3'h4, 18'h3FFFF);
  endtask
  task automatic t_pass;
    cmd(2'h0, 3'h5, 2'h2, 2'h3);
    br(3'h5, 18'h3FFFF);
    bw(3'h5, 1'b0);
    cmd(2'h2, 3'h5, 2'h0, 2'h1);
    cmd(2'h1, 3'h5, 2'h1, 2'h1);
    br(3'h5, 18'h00000);
    cmd(2'h2, 3'h5, 2'h1, 2'h1);
    bw(3'h5, 1'b1);
    br(3'h5, 18'h3FFFF);
  endtask
  task automatic t_lost;
    bw(3'h2, 1'b0);
    cmd(2'h0, 3'h2, 2'h1, 2'h3);
    br(3'h7, 18'h3FFFF);
    bw(3'h2, 1'b1);
    cmd(2'h2, 3'h2, 2'h0, 2'h1);
    cmd(2'h1, 3'h2, 2'h1, 2'h1);
    br(3'h2, 18'h3FFFF);
  endtask
  // whole run is under three hundred cycles, so this is far past it
  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_init();
    t_pass();
    t_lost();
    report_and_stop();
  end
endmodule
`default_nettype wire

/* dps_sem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// two-port token latches
// ****
module dps_sem_model #(parameter int unsigned DATA_W = 18) (
  input wire logic sel_n_a,
  input wire logic we_n_a,
  input wire logic oe_n_a,
  input wire logic [2:0] ix_a,
  input wire logic d_a,
  output logic [DATA_W-1:0] q_a,
  input wire logic sel_n_b,
  input wire logic we_n_b,
  input wire logic oe_n_b,
  input wire logic [2:0] ix_b,
  input wire logic d_b,
  output logic [DATA_W-1:0] q_b
);
  // no power-up init: port a starts with stale requests
  logic [7:0] req_a = 8'h00;
  logic [7:0] req_b = 8'hFF;
  logic [7:0] own_a = 8'h00;
  logic [7:0] own_b = 8'h00;
  logic fa = 1'b1;
  logic fb = 1'b1;
  // latches follow the strobes, no clock; index is three bits only
  always @* begin
    if (!sel_n_a && !we_n_a) req_a[ix_a] = d_a;
    if (!sel_n_b && !we_n_b) req_b[ix_b] = d_b;
    for (int i = 0; i < 8; i++) begin
      if (own_a[i] && req_a[i]) own_a[i] = 1'b0;
      if (own_b[i] && req_b[i]) own_b[i] = 1'b0;
      if (!own_a[i] && !own_b[i]) begin
        if (!req_a[i]) own_a[i] = 1'b1;
        else if (!req_b[i]) own_b[i] = 1'b1;
      end
    end
  end
  // frozen at select and enable so a far write cannot tear a read
  always @(negedge sel_n_a or negedge oe_n_a) begin
    #1 if (!sel_n_a && !oe_n_a) fa = !own_a[ix_a];
  end
  always @(negedge sel_n_b or negedge oe_n_b) #1 if (!sel_n_b && !oe_n_b) fb = !own_b[ix_b];
  // released bus shows the inverse, never the stale value
  assign q_a = (!sel_n_a && !oe_n_a) ? {DATA_W{fa}} : {DATA_W{!fa}};
  // a port with select or output enable high shows the inverse, not a live flag
  assign q_b = (!sel_n_b && !oe_n_b) ? {DATA_W{fb}} : {DATA_W{!fb}};
endmodule
`default_nettype wire
